// File: verilog/dssq_pkg.sv
// constants and types for the debug state sequencer next-state block
package dssq_pkg;

  // avalon slave geometry; registers sit at byte address index*4
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam int          IDX_W      = 6;
  localparam int          IDX_LSB    = 2;
  localparam int          NUM_CH     = 4;
  localparam int          CODE_W     = 4;

  // register indices
  localparam logic [5:0]  IDX_CTRL   = 6'h20;
  localparam logic [5:0]  IDX_STATUS = 6'h21;
  localparam logic [5:0]  IDX_SHARED = 6'h27;

  // debug_control_one and status register fields
  localparam int          CTRL_VIEW_LSB = 0;
  localparam int          CTRL_VIEW_MSB = 1;
  localparam int          CTRL_ARM_BIT  = 7;
  localparam int          STAT_ARM_BIT  = 7;
  localparam int          STAT_ST_MSB   = 2;

  // register_view_select encodings
  localparam logic [1:0]  VIEW_S1    = 2'h0;
  localparam logic [1:0]  VIEW_S2    = 2'h1;
  localparam logic [1:0]  VIEW_S3    = 2'h2;
  localparam logic [1:0]  VIEW_MF    = 2'h3;

  // reset values
  localparam logic [3:0]  CODE_RST   = 4'h0;
  localparam logic [1:0]  VIEW_RST   = 2'h0;
  localparam logic [3:0]  FLAGS_RST  = 4'h0;

  // target of a transition
  localparam logic [1:0]  TGT_S1     = 2'h0;
  localparam logic [1:0]  TGT_S2     = 2'h1;
  localparam logic [1:0]  TGT_S3     = 2'h2;
  localparam logic [1:0]  TGT_FIN    = 2'h3;

  // channel numbers
  localparam logic [1:0]  CH0        = 2'h0;
  localparam logic [1:0]  CH1        = 2'h1;
  localparam logic [1:0]  CH2        = 2'h2;
  localparam logic [1:0]  CH3        = 2'h3;

  typedef enum logic [2:0] {ST_IDLE, ST_S1, ST_S2, ST_S3, ST_FIN} dssq_state_e;

  typedef struct packed {
    logic       valid;
    logic [1:0] target;
  } dssq_move_s;

endpackage

// File: verilog/dssq_match_flags.sv
// sticky per-channel match flags
`timescale 1ns/1ps
module dssq_match_flags
  import dssq_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // control
  input  wire logic              clear,
  input  wire logic              armed,
  input  wire logic [NUM_CH-1:0] match,
  // flags
  output logic      [NUM_CH-1:0] flags
);

  // a match in the clear cycle lands only if already armed: then set wins over clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags <= FLAGS_RST;
    end else if (clear) begin
      flags <= armed ? match : FLAGS_RST;
    end else if (armed) begin
      flags <= flags | match;
    end
  end

endmodule

// File: verilog/dssq_next_state.sv
// next-state decode for states 2 and 3 with channel priority
`timescale 1ns/1ps
module dssq_next_state
  import dssq_pkg::*;
(
  // selection
  input  wire logic              in_state3,
  input  wire logic [CODE_W-1:0] code,
  input  wire logic [NUM_CH-1:0] match,
  // result
  output dssq_move_s             move
);

  function automatic logic [2:0] map_chan(input logic st3, input logic [3:0] c,
                                          input logic [1:0] ch);
    logic [2:0] r;
    r = 3'h0;
    if (!st3) begin
      case (c)
        4'h0: r = {1'b1, TGT_S1};
        4'h1: r = {1'b1, TGT_S3};
        4'h2: r = {1'b1, TGT_FIN};
        4'h3: if (ch == CH3) r = {1'b1, TGT_S1};
        4'h4: if (ch == CH3) r = {1'b1, TGT_S3};
        4'h5: if (ch == CH3) r = {1'b1, TGT_FIN};
        4'h6: if (ch == CH0) r = {1'b1, TGT_S1}; else if (ch == CH1) r = {1'b1, TGT_S3};
        4'h7: if (ch == CH1) r = {1'b1, TGT_S3};
              else if (ch == CH0) r = {1'b1, TGT_FIN};
        4'h8: if (ch == CH0) r = {1'b1, TGT_S1}; else if (ch == CH2) r = {1'b1, TGT_S3};
        4'h9: if (ch == CH2) r = {1'b1, TGT_S3};
              else if (ch == CH0) r = {1'b1, TGT_FIN};
        4'hA: if (ch == CH1) r = {1'b1, TGT_S1}; else if (ch == CH3) r = {1'b1, TGT_S3};
        4'hB: if (ch == CH3) r = {1'b1, TGT_S3};
              else if (ch == CH1) r = {1'b1, TGT_FIN};
        4'hC: if (ch == CH2) r = {1'b1, TGT_S1};
              else if (ch == CH3) r = {1'b1, TGT_FIN};
        4'hD: if (ch != CH2) r = {1'b1, TGT_FIN};
        default: r = 3'h0;
      endcase
    end else begin
      case (c)
        4'h0: r = {1'b1, TGT_S1};
        4'h1: r = {1'b1, TGT_S2};
        4'h2: r = {1'b1, TGT_FIN};
        4'h3: if (ch == CH0) r = {1'b1, TGT_S1};
        4'h4: if (ch == CH0) r = {1'b1, TGT_S2};
        4'h5: if (ch == CH0) r = {1'b1, TGT_FIN};
              else if (ch == CH1) r = {1'b1, TGT_S1};
        4'h6: if (ch == CH1) r = {1'b1, TGT_S1};
        4'h7: if (ch == CH1) r = {1'b1, TGT_S2};
        4'h8: if (ch == CH1) r = {1'b1, TGT_FIN};
        4'h9: if (ch == CH2) r = {1'b1, TGT_S2};
              else if (ch == CH0) r = {1'b1, TGT_FIN};
        4'hA: if (ch == CH1) r = {1'b1, TGT_S1}; else if (ch == CH3) r = {1'b1, TGT_S2};
        4'hB: if (ch == CH3) r = {1'b1, TGT_S2};
              else if (ch == CH1) r = {1'b1, TGT_FIN};
        4'hC: if (ch == CH2) r = {1'b1, TGT_FIN};
        4'hD: if (ch == CH3) r = {1'b1, TGT_FIN};
        default: r = 3'h0;
      endcase
    end
    return r;
  endfunction

  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] to_fin;
  logic [1:0]        tgt [NUM_CH];

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [2:0] m;
    assign m         = map_chan(in_state3, code, 2'(i));
    assign hit[i]    = match[i] & m[2];
    assign tgt[i]    = m[1:0];
    assign to_fin[i] = hit[i] & (m[1:0] == TGT_FIN);
  end

  // final state outranks everything, then the lowest channel
  always_comb begin
    move = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (hit[i]) begin
        move = '{valid: 1'b1, target: tgt[i]};
      end
    end
    if (|to_fin) begin
      move = '{valid: 1'b1, target: TGT_FIN};
    end
  end

endmodule

// File: verilog/dssq_top.sv
// debug state sequencer, states 2/3 next-state registers, match flags, avalon slave
`timescale 1ns/1ps
// What this block does
// - state2 code register shows at shared address with view 01; writable only disarmed
// - state3 code register shows at shared address with view 10; writable only disarmed
// - match flags read at shared address with view 11; writes never change them
// - state2 codes 0-2: any match goes to state1, state3, final
// - state2 codes 3-5: only channel 3 goes to state1, state3, final
// - state2 code 6: ch0 state1, ch1 state3; code 7: ch1 state3, ch0 final
// - state2 code 8: ch0 state1, ch2 state3; code 9: ch2 state3, ch0 final
// - state2 code A: ch1 state1, ch3 state3; code B: ch3 state3, ch1 final
// - state2 code C: channel 2 to state1, channel 3 to final
// - state2 code D: channel 2 ignored, channels 0,1,3 to final
// - codes E and F never cause a transition in states 2 and 3
// - state3 codes 0-2: any match goes to state1, state2, final
// - state3 codes 3 and 4: only channel 0 goes to state1 or state2
// - state3 code 5: channel 0 to final, channel 1 to state1
// - state3 codes 6-8: only channel 1 goes to state1, state2, final
// - state3 code 9: channel 2 to state2, channel 0 to final
// - state3 code A: ch1 state1, ch3 state2; code B: ch3 state2, ch1 final
// - state3 code C: only ch2 to final; code D: only ch3 to final
// - lowest channel wins simultaneous matches; final target beats all others
// - four flags, one per channel, set by a match during a session
// - flags persist after session, software cannot clear, cleared by arming
// - set flag never blocks others; repeat matches change nothing
// - two-bit view select in control register picks the shared-address register
module dssq_top
  import dssq_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  // comparator channels and state1 logic
  input  wire logic [NUM_CH-1:0] match,
  input  wire logic              s1_move,
  input  wire logic [1:0]        s1_target,
  // session status
  output logic                   armed,
  output dssq_state_e            seq_state,
  output logic                   final_hit,
  output logic      [NUM_CH-1:0] match_flags
);

  logic [1:0]        view;
  logic [CODE_W-1:0] scr2;
  logic [CODE_W-1:0] scr3;
  dssq_move_s        mv;

  // bus decode
  logic [IDX_W-1:0]  idx;
  logic              commit;
  logic              wr_lo;
  logic              wr_ctrl;
  logic              wr_shared;
  logic              arm_wr;
  logic              in_eval;
  logic              go_final;

  assign idx       = address[ADDR_W-1:IDX_LSB];
  // one wait state: write data is latched while waitrequest is low
  assign commit    = (read | write) & ~waitrequest;
  assign wr_lo     = write & commit & byteenable[0];
  assign wr_ctrl   = wr_lo & (idx == IDX_CTRL);
  assign wr_shared = wr_lo & (idx == IDX_SHARED);
  assign arm_wr    = wr_ctrl & writedata[CTRL_ARM_BIT];
  assign in_eval   = armed & ((seq_state == ST_S2) | (seq_state == ST_S3));
  assign go_final  = armed & (((seq_state == ST_S1) & s1_move & (s1_target == TGT_FIN))
                    | (in_eval & mv.valid & (mv.target == TGT_FIN)));

  dssq_next_state u_next (
    .in_state3 (seq_state == ST_S3),
    .code      ((seq_state == ST_S3) ? scr3 : scr2),
    .match     (match),
    .move      (mv)
  );

  dssq_match_flags u_flags (
    .clock (clock),
    .rst_n (rst_n),
    .clear (arm_wr),
    .armed (armed),
    .match (match),
    .flags (match_flags)
  );

  // waitrequest idles high and drops for the single accepting cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
    end
  end

  // read data captured one edge before the accepting edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= '0;
    end else if (read & waitrequest) begin
      readdata <= '0;
      case (idx)
        IDX_CTRL: begin
          readdata[CTRL_VIEW_MSB:CTRL_VIEW_LSB] <= view;
          readdata[CTRL_ARM_BIT]                <= armed;
        end
        IDX_STATUS: begin
          readdata[STAT_ST_MSB:0] <= seq_state;
          readdata[STAT_ARM_BIT]  <= armed;
        end
        IDX_SHARED: begin
          case (view)
            VIEW_S2: readdata[CODE_W-1:0] <= scr2;
            VIEW_S3: readdata[CODE_W-1:0] <= scr3;
            VIEW_MF: readdata[NUM_CH-1:0] <= match_flags;
            default: readdata <= '0;
          endcase
        end
        default: readdata <= '0;
      endcase
    end
  end

  // view select is writable at any time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      view <= VIEW_RST;
    end else if (wr_ctrl) begin
      view <= writedata[CTRL_VIEW_MSB:CTRL_VIEW_LSB];
    end
  end

  // code registers frozen while armed so a live session cannot be re-steered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scr2 <= CODE_RST;
      scr3 <= CODE_RST;
    end else if (wr_shared & ~armed) begin
      if (view == VIEW_S2) begin
        scr2 <= writedata[CODE_W-1:0];
      end
      if (view == VIEW_S3) begin
        scr3 <= writedata[CODE_W-1:0];
      end
    end
  end

  // arm bit: set by software, cleared by software or on reaching final
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (wr_ctrl) begin
      armed <= writedata[CTRL_ARM_BIT];
    end else if (go_final) begin
      armed <= 1'b0;
    end
  end

  // sequencer state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_state <= ST_IDLE;
    end else if (arm_wr) begin
      seq_state <= ST_S1;
    end else if (armed) begin
      case (seq_state)
        ST_S1: begin
          if (s1_move) begin
            case (s1_target)
              TGT_S2:  seq_state <= ST_S2;
              TGT_S3:  seq_state <= ST_S3;
              TGT_FIN: seq_state <= ST_FIN;
              default: seq_state <= ST_S1;
            endcase
          end
        end
        ST_S2, ST_S3: begin
          if (mv.valid) begin
            case (mv.target)
              TGT_S1:  seq_state <= ST_S1;
              TGT_S2:  seq_state <= ST_S2;
              TGT_S3:  seq_state <= ST_S3;
              default: seq_state <= ST_FIN;
            endcase
          end
        end
        default: seq_state <= seq_state;
      endcase
    end
  end

  // one-cycle pulse when the session reaches final state without a control write in that cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      final_hit <= 1'b0;
    end else begin
      final_hit <= go_final & ~wr_ctrl;
    end
  end

  property p_scr2_write;
    @(posedge clock) disable iff (!rst_n)
      wr_shared && !armed && view == VIEW_S2 |=> scr2 == $past(writedata[CODE_W-1:0]);
  endproperty
  a_scr2_write: assert property (p_scr2_write)
    else $error("state2 code not written");

  property p_locked;
    @(posedge clock) disable iff (!rst_n)
      armed && !wr_ctrl |=> $stable(scr2) && $stable(scr3);
  endproperty
  a_locked: assert property (p_locked)
    else $error("code register changed while armed");

  property p_flags_ro;
    @(posedge clock) disable iff (!rst_n)
      !arm_wr && !(armed && |match) |=> $stable(match_flags);
  endproperty
  a_flags_ro: assert property (p_flags_ro)
    else $error("match flags changed without match or arming");

  property p_s2_any;
    @(posedge clock) disable iff (!rst_n)
      armed && !wr_ctrl && seq_state == ST_S2 && scr2 == 4'h0 && match[0]
      |=> seq_state == ST_S1;
  endproperty
  a_s2_any: assert property (p_s2_any)
    else $error("state2 code 0 did not go to state1");

  property p_reserved;
    @(posedge clock) disable iff (!rst_n)
      armed && !wr_ctrl && seq_state == ST_S3 && scr3[3:1] == 3'h7 |=> $stable(seq_state);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved code caused a transition");

  property p_final_wins;
    @(posedge clock) disable iff (!rst_n)
      in_eval && !wr_ctrl && mv.valid && mv.target == TGT_FIN
      |=> seq_state == ST_FIN && !armed ##1 !final_hit;
  endproperty
  a_final_wins: assert property (p_final_wins)
    else $error("final target not taken or pulse too long");

  property p_flag_set;
    @(posedge clock) disable iff (!rst_n)
      armed && |match |=> (match_flags & $past(match)) == $past(match);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("matched channel flag not set");

  property p_arm_clear;
    @(posedge clock) disable iff (!rst_n)
      arm_wr && !armed |=> match_flags == FLAGS_RST && seq_state == ST_S1;
  endproperty
  a_arm_clear: assert property (p_arm_clear)
    else $error("arming did not clear flags");

  property p_view_read;
    @(posedge clock) disable iff (!rst_n)
      read && !waitrequest && idx == IDX_SHARED && view == VIEW_S2 && !$past(wr_lo)
      |-> readdata == {28'h0, scr2};
  endproperty
  a_view_read: assert property (p_view_read)
    else $error("shared read did not return state2 code");

  property p_idle_hold;
    @(posedge clock) disable iff (!rst_n)
      !armed && !arm_wr |=> $stable(seq_state);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("sequencer moved while disarmed");

  property p_s2_ch3_only;
    @(posedge clock) disable iff (!rst_n)
      armed && !wr_ctrl && seq_state == ST_S2 && scr2 inside {4'h3, 4'h4, 4'h5} && !match[3]
      |=> $stable(seq_state);
  endproperty
  a_s2_ch3_only: assert property (p_s2_ch3_only)
    else $error("state2 codes 3 to 5 moved without a channel 3 match");

  property p_s2_code7_fin;
    @(posedge clock) disable iff (!rst_n)
      armed && !wr_ctrl && seq_state == ST_S2 && scr2 == 4'h7 && match[0]
      |=> seq_state == ST_FIN;
  endproperty
  a_s2_code7_fin: assert property (p_s2_code7_fin)
    else $error("state2 code 7 channel 0 did not reach final");

  property p_s2_codeA_s1;
    @(posedge clock) disable iff (!rst_n)
      armed && !wr_ctrl && seq_state == ST_S2 && scr2 == 4'hA && match[1]
      |=> seq_state == ST_S1;
  endproperty
  a_s2_codeA_s1: assert property (p_s2_codeA_s1)
    else $error("state2 code A channel 1 did not reach state1");

  property p_s2_codeC_fin;
    @(posedge clock) disable iff (!rst_n)
      armed && !wr_ctrl && seq_state == ST_S2 && scr2 == 4'hC && match[3]
      |=> seq_state == ST_FIN;
  endproperty
  a_s2_codeC_fin: assert property (p_s2_codeC_fin)
    else $error("state2 code C channel 3 did not reach final");

  property p_s2_codeD_ch2;
    @(posedge clock) disable iff (!rst_n)
      armed && !wr_ctrl && seq_state == ST_S2 && scr2 == 4'hD && match == 4'h4
      |=> $stable(seq_state);
  endproperty
  a_s2_codeD_ch2: assert property (p_s2_codeD_ch2)
    else $error("state2 code D moved on channel 2 alone");

  property p_s3_ch0_only;
    @(posedge clock) disable iff (!rst_n)
      armed && !wr_ctrl && seq_state == ST_S3 && scr3 inside {4'h3, 4'h4} && !match[0]
      |=> $stable(seq_state);
  endproperty
  a_s3_ch0_only: assert property (p_s3_ch0_only)
    else $error("state3 codes 3 and 4 moved without a channel 0 match");

  property p_s3_ch1_only;
    @(posedge clock) disable iff (!rst_n)
      armed && !wr_ctrl && seq_state == ST_S3 && scr3 inside {4'h6, 4'h7, 4'h8} && !match[1]
      |=> $stable(seq_state);
  endproperty
  a_s3_ch1_only: assert property (p_s3_ch1_only)
    else $error("state3 codes 6 to 8 moved without a channel 1 match");

  property p_s3_code9_s2;
    @(posedge clock) disable iff (!rst_n)
      armed && !wr_ctrl && seq_state == ST_S3 && scr3 == 4'h9 && match[2] && !match[0]
      |=> seq_state == ST_S2;
  endproperty
  a_s3_code9_s2: assert property (p_s3_code9_s2)
    else $error("state3 code 9 channel 2 did not reach state2");

  property p_flags_sticky;
    @(posedge clock) disable iff (!rst_n)
      !arm_wr |=> (match_flags & $past(match_flags)) == $past(match_flags);
  endproperty
  a_flags_sticky: assert property (p_flags_sticky)
    else $error("a match flag dropped without arming");

endmodule

// File: tb/tb.sv
// self-checking bench for the state2/state3 next-state selection and match flags
`timescale 1ns/1ps
module tb;
  import dssq_pkg::*;

  localparam int LIMIT = 20000;

  logic              clock;
  logic              rst_n;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [DATA_W-1:0] writedata;
  logic [3:0]        byteenable;
  logic [DATA_W-1:0] readdata;
  logic              waitrequest;
  logic [NUM_CH-1:0] match;
  logic              s1_move;
  logic [1:0]        s1_target;
  logic              armed;
  dssq_state_e       seq_state;
  logic              final_hit;
  logic [NUM_CH-1:0] match_flags;
  int                mismatches = 0;
  int                n_compared = 0;
  int                cycles     = 0;
  logic [3:0]        be_lane    = 4'hF;

  // entry digits: state, code, match, expected state (1 s1, 2 s2, 3 s3, 4 final)
  logic [15:0]       tbl [$] = {
    16'h2081, 16'h2123, 16'h2214,
    16'h2372, 16'h2381, 16'h2483, 16'h2412, 16'h2584,
    16'h2611, 16'h2623, 16'h2631, 16'h26C2,
    16'h2734, 16'h2723, 16'h27C2,
    16'h2843, 16'h2851, 16'h28A2, 16'h2954, 16'h2943,
    16'h2AA1, 16'h2A83, 16'h2A52, 16'h2BA4, 16'h2B83,
    16'h2CC4, 16'h2C41, 16'h2C32,
    16'h2D42, 16'h2D84, 16'h2D14,
    16'h2EF2, 16'h2FF2, 16'h3EF3, 16'h3FF3,
    16'h3041, 16'h3182, 16'h3224,
    16'h3311, 16'h33E3, 16'h3412, 16'h34E3,
    16'h3534, 16'h3521, 16'h35C3,
    16'h3621, 16'h36D3, 16'h3722, 16'h3824, 16'h38D3,
    16'h3954, 16'h3942, 16'h39A3,
    16'h3AA1, 16'h3A82, 16'h3A53, 16'h3BA4, 16'h3B82,
    16'h3C44, 16'h3CB3, 16'h3D84, 16'h3D73
  };

  dssq_top i_dut (
    .clock       (clock),
    .rst_n       (rst_n),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .match       (match),
    .s1_move     (s1_move),
    .s1_target   (s1_target),
    .armed       (armed),
    .seq_state   (seq_state),
    .final_hit   (final_hit),
    .match_flags (match_flags)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hung handshake ends here rather than stalling the run
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      close_out;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // request held until waitrequest is sampled low; read data taken at that edge
  task automatic bus(input logic wr_n_rd, input logic [5:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    address    <= {idx, 2'b00};
    write      <= wr_n_rd;
    read       <= ~wr_n_rd;
    writedata  <= {24'hFFFFFF, d};
    byteenable <= be_lane;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(name, exp, q);
  endtask

  // one cycle of match and state1 move request, then settle past the sampling edge
  task automatic step(input logic [3:0] m, input logic mv, input logic [1:0] tg);
    @(posedge clock);
    match     <= m;
    s1_move   <= mv;
    s1_target <= tg;
    @(posedge clock);
    match     <= 4'h0;
    s1_move   <= 1'b0;
    #1;
  endtask

  task automatic t_regs;
    chk("waitrequest idle", 32'h1, {31'h0, waitrequest});
    chk("armed reset", 32'h0, {31'h0, armed});
    chk("flags reset", 32'h0, {28'h0, match_flags});
    chk("state reset", {29'h0, ST_IDLE}, {29'h0, seq_state});
    rd_chk("shared view 00", IDX_SHARED, 32'h0);
    rd_chk("unmapped read", 6'h3F, 32'h0);
    wr(IDX_CTRL, {6'h00, VIEW_S2});
    rd_chk("state2 code reset", IDX_SHARED, {28'h0, CODE_RST});
    wr(IDX_CTRL, {6'h00, VIEW_S3});
    rd_chk("state3 code reset", IDX_SHARED, 32'h0);
    wr(IDX_SHARED, 8'hF7);
    rd_chk("state3 code", IDX_SHARED, 32'h7);
    rd_chk("ctrl view", IDX_CTRL, {30'h0, VIEW_S3});
    wr(IDX_CTRL, {6'h00, VIEW_S2});
    wr(IDX_SHARED, 8'h0A);
    rd_chk("state2 code", IDX_SHARED, 32'hA);
    // lane 0 off: the write must be dropped
    be_lane = 4'hE;
    wr(IDX_SHARED, 8'h05);
    be_lane = 4'hF;
    rd_chk("lane 0 off ignored", IDX_SHARED, 32'hA);
    wr(6'h3F, 8'h55);
    // armed: both code registers must refuse writes
    wr(IDX_CTRL, {1'b1, 5'h00, VIEW_S2});
    wr(IDX_SHARED, 8'h03);
    rd_chk("state2 locked", IDX_SHARED, 32'hA);
    wr(IDX_CTRL, {1'b1, 5'h00, VIEW_S3});
    wr(IDX_SHARED, 8'h01);
    rd_chk("state3 locked", IDX_SHARED, 32'h7);
    wr(IDX_CTRL, {6'h00, VIEW_S1});
    wr(IDX_SHARED, 8'h05);
    rd_chk("view 00 write ignored", IDX_SHARED, 32'h0);
    rd_chk("unmapped after write", 6'h3F, 32'h0);
  endtask

  task automatic t_table;
    logic [3:0] s;
    logic [1:0] view;
    foreach (tbl[i]) begin
      s    = tbl[i][15:12];
      view = (s == 4'h2) ? VIEW_S2 : VIEW_S3;
      wr(IDX_CTRL, {6'h00, view});
      wr(IDX_SHARED, {4'h0, tbl[i][11:8]});
      wr(IDX_CTRL, {1'b1, 5'h00, view});
      step(4'h0, 1'b1, (s == 4'h2) ? TGT_S2 : TGT_S3);
      chk("entry state", {28'h0, s}, {29'h0, seq_state});
      step(tbl[i][7:4], 1'b0, TGT_S1);
      chk("next state", {29'h0, tbl[i][2:0]}, {29'h0, seq_state});
      chk("final pulse", {31'h0, tbl[i][2:0] == 3'h4}, {31'h0, final_hit});
      chk("flags", {28'h0, tbl[i][7:4]}, {28'h0, match_flags});
    end
  endtask

  task automatic t_flags;
    dssq_state_e held;
    wr(IDX_CTRL, {6'h00, VIEW_S2});
    wr(IDX_SHARED, 8'h0E);
    wr(IDX_CTRL, {1'b1, 5'h00, VIEW_MF});
    step(4'h0, 1'b1, TGT_S2);
    step(4'h1, 1'b0, TGT_S1);
    step(4'h4, 1'b0, TGT_S1);
    step(4'h1, 1'b0, TGT_S1);
    chk("flags accumulate", 32'h5, {28'h0, match_flags});
    chk("reserved code holds", {29'h0, ST_S2}, {29'h0, seq_state});
    rd_chk("status", IDX_STATUS, {24'h0, 1'b1, 4'h0, ST_S2});
    wr(IDX_SHARED, 8'h00);
    rd_chk("flags read", IDX_SHARED, 32'h5);
    // disarmed with a code that would move on any match
    wr(IDX_CTRL, {6'h00, VIEW_S2});
    wr(IDX_SHARED, 8'h00);
    held = seq_state;
    step(4'h2, 1'b0, TGT_S1);
    chk("disarmed no move", {29'h0, held}, {29'h0, seq_state});
    chk("disarmed no flag", 32'h5, {28'h0, match_flags});
    wr(IDX_CTRL, {6'h00, VIEW_MF});
    rd_chk("flags persist", IDX_SHARED, 32'h5);
    wr(IDX_CTRL, {1'b1, 5'h00, VIEW_MF});
    rd_chk("flags cleared by arm", IDX_SHARED, 32'h0);
    // state1 logic asks for final: session ends with a one-cycle pulse
    step(4'h0, 1'b1, TGT_FIN);
    chk("s1 to final", {29'h0, ST_FIN}, {29'h0, seq_state});
    chk("final disarms", 32'h0, {31'h0, armed});
    chk("final pulse s1", 32'h1, {31'h0, final_hit});
    @(posedge clock);
    #1;
    chk("final pulse ends", 32'h0, {31'h0, final_hit});
    wr(IDX_CTRL, 8'h00);
  endtask

  initial begin
    rst_n      = 1'b0;
    address    = '0;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = '0;
    byteenable = 4'h0;
    match      = 4'h0;
    s1_move    = 1'b0;
    s1_target  = TGT_S1;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    t_regs;
    t_table;
    t_flags;
    close_out;
  end
endmodule
